// file: rtl/xreg_cfg.svh
// offsets, field positions, reset values and timing figures of the indirect access block
`ifndef XREG_CFG_SVH
`define XREG_CFG_SVH

`define XR_ACR_OFS    5'h0d
`define XR_PORT_OFS   5'h0e
`define XR_FLDS_OFS   5'h0c
`define XR_DEV_ALL1   5'h1f
`define XR_RST16      16'h0000
`define XR_RST5       5'h00
`define XR_FN_MSB     15
`define XR_FN_LSB     14
`define XR_DEV_MSB    4
`define XR_DEV_LSB    0
`define XR_FLDS_LSB   4
`define XR_FLDS_MSB   8
`define XR_PTR_STEP   16'h0001
`define XR_WIN_NS     10000
`define XR_CLK_NS     20
`define XR_RXERR_THR  32
`define XR_MLT3_THR   20
`define XR_SNR_THR    20
`define XR_EXT_AW     5

`endif

// file: rtl/xreg_pkg.sv
// types shared by the indirect access block and its test bench
`default_nettype none
package xreg_pkg;

  // function field of the access control register
  typedef enum logic [1:0] {
    FN_ADDR   = 2'b00,
    FN_DATA   = 2'b01,
    FN_INC_RW = 2'b10,
    FN_INC_WR = 2'b11
  } xfn_t;

  // access control register layout
  typedef struct packed {
    xfn_t       fn;
    logic [8:0] rsvd;
    logic [4:0] target_device_address;
  } acr_t;

  // one management access, single-cycle strobes
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } mgmt_req_t;

  // link-drop criteria, bit order as in the cause register
  typedef struct packed {
    logic descr;
    logic rxerr;
    logic mlt3;
    logic snr;
    logic energy;
  } fld_vec_t;

endpackage
`default_nettype wire

// file: rtl/ext_reg_mem.sv
// extended register storage with registered read data
`default_nettype none
module ext_reg_mem #(
  parameter int DW = 16,
  parameter int AW = 5
) (
  input  wire  logic          mclk,
  input  wire  logic          rst,
  input  wire  logic          we,
  input  wire  logic [AW-1:0] addr,
  input  wire  logic [DW-1:0] wdata,
  output logic       [DW-1:0] rdata
);
  logic [DW-1:0] mem_q [2**AW];
  logic [DW-1:0] mem_d [2**AW];
  logic [DW-1:0] rdata_d;

  initial begin
    if (DW < 1 || AW < 1) $error("ext_reg_mem: bad geometry");
  end

  // write one word, read the addressed word before the write
  always_comb begin
    mem_d   = mem_q;
    rdata_d = mem_q[addr];
    if (we) begin
      mem_d[addr] = wdata;
    end
  end

  // registers clear to zero so unwritten locations read as reset value
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 2**AW; i++) begin
        mem_q[i] <= '0;
      end
      rdata <= '0;
    end else begin
      mem_q <= mem_d;
      rdata <= rdata_d;
    end
  end
endmodule
`default_nettype wire

// file: rtl/extended_register_indirect_access.sv
// indirect extended register access and link-drop cause latch
`include "xreg_cfg.svh"
`default_nettype none
module extended_register_indirect_access #(
  parameter int EXT_AW    = `XR_EXT_AW,
  parameter int RXERR_THR = `XR_RXERR_THR,
  parameter int MLT3_THR  = `XR_MLT3_THR,
  parameter int SNR_THR   = `XR_SNR_THR
) (
  input  wire  logic                mclk,
  input  wire  logic                rst,
  input  wire  xreg_pkg::mgmt_req_t req,
  output logic [15:0]               rdata,
  output logic                      rvalid,
  input  wire  xreg_pkg::fld_vec_t  fld_enable,
  input  wire  xreg_pkg::fld_vec_t  fld_event,
  output logic                      link_drop
);
  import xreg_pkg::*;

  localparam int WIN_CYC = `XR_WIN_NS / `XR_CLK_NS;
  localparam int WW      = $clog2(WIN_CYC + 1);
  localparam int CW      = 6;
  localparam logic [WW-1:0] WIN_LAST = WW'(WIN_CYC - 1);

  initial begin
    if (EXT_AW < 1 || EXT_AW > 16) $error("EXT_AW out of range");
    if (RXERR_THR < 1 || RXERR_THR >= 2**CW) $error("RXERR_THR out of range");
    if (MLT3_THR < 1 || MLT3_THR >= 2**CW) $error("MLT3_THR out of range");
    if (SNR_THR < 1 || SNR_THR >= 2**CW) $error("SNR_THR out of range");
  end

  acr_t          acr_q, acr_d;
  logic [15:0]   ptr_q, ptr_d;
  logic [15:0]   rdata_q, rdata_d;
  logic          rsel_q, rsel_d;
  logic          rvalid_q, rvalid_d;
  fld_vec_t      cause_q, cause_d;
  logic          mem_we;
  logic [15:0]   mem_rdata;
  logic          dev_ok, in_range, port_wr, port_rd;

  // one step of an occurrence counter inside the window; msb is the drop hit
  function automatic logic [CW:0] cnt_step(input logic [CW-1:0] cnt, input logic evt,
                                           input logic en, input int thr, input logic wend);
    logic          hit;
    logic [CW-1:0] nxt;
    hit = en && evt && (int'(cnt) + 1 >= thr);
    nxt = (!en || hit || wend) ? '0 : cnt + CW'(evt);
    return {hit, nxt};
  endfunction

  ext_reg_mem #(.DW(16), .AW(EXT_AW)) u_mem (
    .mclk  (mclk),
    .rst   (rst),
    .we    (mem_we),
    .addr  (ptr_q[EXT_AW-1:0]),
    .wdata (req.wdata),
    .rdata (mem_rdata)
  );

  assign dev_ok   = (acr_q.target_device_address == `XR_DEV_ALL1);
  assign in_range = (EXT_AW >= 16) ? 1'b1 : ((ptr_q >> EXT_AW) == `XR_RST16);
  // data port decode; a write wins over a read in the same cycle
  assign port_wr  = req.wr && (req.addr == `XR_PORT_OFS) && dev_ok;
  assign port_rd  = req.rd && !req.wr && (req.addr == `XR_PORT_OFS) && dev_ok;

  // link-drop detectors
  logic [WW-1:0]  win_q, win_d;
  logic [CW-1:0]  rx_cnt_q, rx_cnt_d, ml_cnt_q, ml_cnt_d, sn_cnt_q, sn_cnt_d;
  fld_vec_t       fld_set;
  logic           drop_q, drop_d;

  // free window timer; all counters restart together at each window end
  always_comb begin
    logic wend;
    logic [CW:0] rx_s, ml_s, sn_s;
    wend = (win_q == WIN_LAST);
    rx_s = '0;
    ml_s = '0;
    sn_s = '0;
    win_d = wend ? '0 : win_q + WW'(1);
    rx_s = cnt_step(rx_cnt_q, fld_event.rxerr, fld_enable.rxerr, RXERR_THR, wend);
    ml_s = cnt_step(ml_cnt_q, fld_event.mlt3, fld_enable.mlt3, MLT3_THR, wend);
    sn_s = cnt_step(sn_cnt_q, fld_event.snr, fld_enable.snr, SNR_THR, wend);
    rx_cnt_d = rx_s[CW-1:0];
    ml_cnt_d = ml_s[CW-1:0];
    sn_cnt_d = sn_s[CW-1:0];
    // each cause gated by its enable
    fld_set.descr  = fld_enable.descr && fld_event.descr;
    fld_set.rxerr  = rx_s[CW];
    fld_set.mlt3   = ml_s[CW];
    fld_set.snr    = sn_s[CW];
    fld_set.energy = fld_enable.energy && fld_event.energy;
    // any enabled criterion drops the link
    drop_d = |fld_set;
  end

  // detector state
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      win_q    <= '0;
      rx_cnt_q <= '0;
      ml_cnt_q <= '0;
      sn_cnt_q <= '0;
      drop_q   <= 1'b0;
    end else begin
      win_q    <= win_d;
      rx_cnt_q <= rx_cnt_d;
      ml_cnt_q <= ml_cnt_d;
      sn_cnt_q <= sn_cnt_d;
      drop_q   <= drop_d;
    end
  end

  // register access
  // reads answer one cycle after the strobe; unmapped offsets read zero
  always_comb begin
    acr_d    = acr_q;
    ptr_d    = ptr_q;
    rdata_d  = `XR_RST16;
    rsel_d   = 1'b0;
    rvalid_d = req.rd && !req.wr;
    mem_we   = 1'b0;
    cause_d  = cause_q;
    if (req.wr && req.addr == `XR_ACR_OFS) begin
      acr_d.fn    = xfn_t'(req.wdata[`XR_FN_MSB:`XR_FN_LSB]);
      acr_d.rsvd  = '0;
      acr_d.target_device_address = req.wdata[`XR_DEV_MSB:`XR_DEV_LSB];
    end
    if (port_wr) begin
      unique case (acr_q.fn)
        FN_ADDR:   ptr_d = req.wdata;
        FN_DATA:   mem_we = in_range;
        // post increment after writes, wraps at top
        FN_INC_RW,
        FN_INC_WR: begin
          mem_we = in_range;
          ptr_d  = ptr_q + `XR_PTR_STEP;
        end
      endcase
    end
    if (port_rd) begin
      if (acr_q.fn == FN_ADDR) begin
        rdata_d = ptr_q;
      end else begin
        rsel_d = in_range;
      end
      // only function 10 steps on reads
      if (acr_q.fn == FN_INC_RW) begin
        ptr_d = ptr_q + `XR_PTR_STEP;
      end
    end
    if (req.rd && !req.wr && req.addr == `XR_ACR_OFS) begin
      rdata_d = acr_q;
    end
    if (req.rd && !req.wr && req.addr == `XR_FLDS_OFS) begin
      rdata_d[`XR_FLDS_MSB:`XR_FLDS_LSB] = cause_q;
      // read clears, a cause in the same cycle survives
      cause_d = '0;
    end
    // latch high; set wins over the read clear
    cause_d = cause_d | fld_set;
  end

  // register state; all control fields reset to zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      acr_q    <= '0;
      ptr_q    <= `XR_RST16;
      rdata_q  <= `XR_RST16;
      rsel_q   <= 1'b0;
      rvalid_q <= 1'b0;
      cause_q  <= '0;
    end else begin
      acr_q    <= acr_d;
      ptr_q    <= ptr_d;
      rdata_q  <= rdata_d;
      rsel_q   <= rsel_d;
      rvalid_q <= rvalid_d;
      cause_q  <= cause_d;
    end
  end

  // memory data already leaves a flop, so only a mux follows it
  assign rdata     = rsel_q ? mem_rdata : rdata_q;
  assign rvalid    = rvalid_q;
  assign link_drop = drop_q;

  // checks on the register and cause logic
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  addr_load_a: assert property (port_wr && acr_q.fn == FN_ADDR |=> ptr_q == $past(req.wdata))
    else $error("pointer not loaded by address write");
  data_hold_a: assert property ((port_wr || port_rd) && acr_q.fn == FN_DATA |=> $stable(ptr_q))
    else $error("pointer moved on plain data access");
  inc_rw_a: assert property (port_rd && acr_q.fn == FN_INC_RW
                             |=> ptr_q == $past(ptr_q) + `XR_PTR_STEP)
    else $error("pointer not stepped after read");
  inc_wr_a: assert property (port_wr && acr_q.fn == FN_INC_WR
                             |=> ptr_q == $past(ptr_q) + `XR_PTR_STEP)
    else $error("pointer not stepped after write");
  rd_hold_a: assert property (port_rd && acr_q.fn == FN_INC_WR |=> $stable(ptr_q))
    else $error("pointer moved on read in write-step mode");
  ptr_read_a: assert property (port_rd && acr_q.fn == FN_ADDR
                               |=> rvalid && rdata == $past(ptr_q))
    else $error("port read did not return pointer");
  dev_gate_a: assert property (req.addr == `XR_PORT_OFS && (req.rd || req.wr) && !dev_ok
                               |=> $stable(ptr_q) ##1 $stable(ptr_q))
    else $error("access with wrong device address took effect");
  acr_rsvd_a: assert property (req.rd && !req.wr && req.addr == `XR_ACR_OFS
                               |=> rvalid && rdata[13:5] == 9'h000)
    else $error("reserved control bits read nonzero");
  flds_rsvd_a: assert property (req.rd && !req.wr && req.addr == `XR_FLDS_OFS
                                |=> rdata[15:9] == 7'h00 && rdata[3:0] == 4'h0)
    else $error("reserved status bits read nonzero");
  cause_en_a: assert property ($rose(cause_q.rxerr) |-> $past(fld_enable.rxerr))
    else $error("cause latched while criterion disabled");
  drop_cause_a: assert property (|fld_set |=> link_drop && (cause_q & $past(fld_set)) != '0)
    else $error("link drop without latched cause");
  rd_clear_a: assert property (req.rd && !req.wr && req.addr == `XR_FLDS_OFS && !(|fld_set)
                               |=> cause_q == '0)
    else $error("cause not cleared by status read");

  inc_walk_c: cover property (port_rd && acr_q.fn == FN_INC_RW ##1 port_rd);
  rx_drop_c: cover property (fld_set.rxerr ##1 link_drop);
  set_clr_c: cover property (req.rd && req.addr == `XR_FLDS_OFS && |fld_set);
  ptr_wrap_c: cover property (port_wr && acr_q.fn != FN_ADDR && ptr_q == 16'hffff);
endmodule
`default_nettype wire

// file: test/mgmt_station.sv
// management station model issuing single-cycle register strobes
`include "xreg_cfg.svh"
`default_nettype none
module mgmt_station
  import xreg_pkg::*;
(
  input  wire logic        mclk,
  output var  mgmt_req_t   req,
  input  wire logic [15:0] rdata,
  input  wire logic        rvalid
);
  timeunit 1ns;
  timeprecision 1ps;

  initial req = '0;

  // one write; released lines show the inverse so stale values never pass
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk) req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge mclk) req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask

  // one read; answer taken at the edge where rvalid is due
  task automatic rd(input logic [4:0] a, output logic [16:0] got);
    @(posedge mclk) req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
    @(posedge mclk) req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 16'hffff};
    @(posedge mclk) got = {rvalid, rdata};
  endtask

  task automatic ctl(input xfn_t fn);
    wr(`XR_ACR_OFS, {fn, 9'h000, `XR_DEV_ALL1});
  endtask

  task automatic seek(input logic [15:0] p, input xfn_t fn);
    ctl(FN_ADDR);
    wr(`XR_PORT_OFS, p);
    ctl(fn);
  endtask
endmodule
`default_nettype wire

// file: test/extended_register_indirect_access_test.sv
// self-checking bench for the indirect access block
`include "xreg_cfg.svh"
`default_nettype none
module extended_register_indirect_access_test
  import xreg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        mclk = 1'b0;
  logic        rst  = 1'b1;
  mgmt_req_t   req;
  logic [15:0] rdata;
  logic        rvalid;
  fld_vec_t    fld_enable = '0;
  fld_vec_t    fld_event  = '0;
  logic        link_drop;
  int          bad_count = 0;
  int          checks = 0;
  int          drops = 0;
  int          cycles = 0;
  logic [16:0] got;

  // window length in cycles; thresholds are tried early in a window so
  // no window boundary can split an exact-count burst
  localparam int WIN_CYC   = `XR_WIN_NS / `XR_CLK_NS;
  localparam int WIN_START = 100;

  always #10 mclk = ~mclk;

  extended_register_indirect_access dut (
    .mclk       (mclk),
    .rst        (rst),
    .req        (req),
    .rdata      (rdata),
    .rvalid     (rvalid),
    .fld_enable (fld_enable),
    .fld_event  (fld_event),
    .link_drop  (link_drop)
  );

  mgmt_station mc (
    .mclk   (mclk),
    .req    (req),
    .rdata  (rdata),
    .rvalid (rvalid)
  );

  task automatic print_verdict();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // drop pulses are counted here; the whole run is far below the ceiling
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (link_drop === 1'b1) drops <= drops + 1;
    if (cycles == 20000) begin
      bad_count = bad_count + 1;
      print_verdict();
    end
  end

  task automatic chk(input logic [16:0] g, input logic [16:0] e);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // a read must answer with rvalid and the expected word
  task automatic rdchk(input logic [4:0] a, input logic [15:0] e);
    mc.rd(a, got);
    chk(got, {1'b1, e});
  endtask

  task automatic t_regs();
    rdchk(`XR_ACR_OFS, 16'h0000);
    rdchk(`XR_PORT_OFS, 16'h0000);
    rdchk(`XR_FLDS_OFS, 16'h0000);
    mc.wr(`XR_ACR_OFS, 16'hffff);
    rdchk(`XR_ACR_OFS, 16'hc01f);
    mc.ctl(FN_ADDR);
    rdchk(`XR_PORT_OFS, 16'h0000);
    mc.wr(5'h03, 16'h1234);
    rdchk(5'h03, 16'h0000);
    mc.seek(16'h0005, FN_ADDR);
    rdchk(`XR_PORT_OFS, 16'h0005);
  endtask

  task automatic t_modes();
    mc.seek(16'h0003, FN_DATA);
    mc.wr(`XR_PORT_OFS, 16'ha5a5);
    mc.wr(`XR_PORT_OFS, 16'h5a5a);
    rdchk(`XR_PORT_OFS, 16'h5a5a);
    mc.ctl(FN_ADDR);
    rdchk(`XR_PORT_OFS, 16'h0003);
    mc.seek(16'h0008, FN_INC_RW);
    for (int i = 0; i < 4; i++) mc.wr(`XR_PORT_OFS, 16'h1100 + 16'(i));
    mc.seek(16'h0008, FN_INC_RW);
    for (int i = 0; i < 4; i++) rdchk(`XR_PORT_OFS, 16'h1100 + 16'(i));
    mc.ctl(FN_ADDR);
    rdchk(`XR_PORT_OFS, 16'h000c);
    mc.seek(16'h0008, FN_INC_WR);
    rdchk(`XR_PORT_OFS, 16'h1100);
    rdchk(`XR_PORT_OFS, 16'h1100);
    mc.wr(`XR_PORT_OFS, 16'h2200);
    mc.ctl(FN_ADDR);
    rdchk(`XR_PORT_OFS, 16'h0009);
    mc.seek(16'h0008, FN_DATA);
    rdchk(`XR_PORT_OFS, 16'h2200);
  endtask

  // wrong device address must leave pointer and data alone
  task automatic t_target_device_address_wrap();
    mc.wr(`XR_ACR_OFS, {FN_INC_RW, 9'h000, 5'h1e});
    mc.wr(`XR_PORT_OFS, 16'hdead);
    rdchk(`XR_PORT_OFS, 16'h0000);
    mc.ctl(FN_ADDR);
    rdchk(`XR_PORT_OFS, 16'h0008);
    mc.ctl(FN_DATA);
    rdchk(`XR_PORT_OFS, 16'h2200);
    mc.seek(16'hffff, FN_INC_RW);
    mc.wr(`XR_PORT_OFS, 16'h0001);
    mc.ctl(FN_ADDR);
    rdchk(`XR_PORT_OFS, 16'h0000);
  endtask

  task automatic pulse(input fld_vec_t ev, input int n);
    repeat (n) @(posedge mclk) fld_event <= ev;
    @(posedge mclk) fld_event <= '0;
    repeat (4) @(posedge mclk);
  endtask

  // bursts of twice the threshold fire whatever the window phase
  task automatic t_drop();
    fld_vec_t ev;
    int       n;
    int       base;
    for (int i = 0; i < 5; i++) begin
      ev = fld_vec_t'(5'h01 << i);
      n = (i == 3) ? `XR_RXERR_THR : (i == 2) ? `XR_MLT3_THR : (i == 1) ? `XR_SNR_THR : 1;
      @(posedge mclk) fld_enable <= '0;
      base = drops;
      pulse(ev, 2 * n);
      chk(17'(drops - base), 17'h00000);
      @(posedge mclk) fld_enable <= ev;
      while (cycles % WIN_CYC != WIN_START) @(posedge mclk);
      pulse(ev, n - 1);
      chk(17'(drops - base), 17'h00000);
      pulse(ev, 1);
      chk(17'(drops - base), 17'h00001);
      base = drops;
      pulse(ev, 2 * n);
      chk(17'(drops != base), 17'h00001);
      rdchk(`XR_FLDS_OFS, 16'h0010 << i);
      rdchk(`XR_FLDS_OFS, 16'h0000);
    end
  endtask

  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_modes();
    t_target_device_address_wrap();
    t_drop();
    print_verdict();
  end
endmodule
`default_nettype wire
